// >>> core/icw_top.sv
// Register access over AHB-Lite was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "icw_regs.svh"

// Contract
// - Reset starts execution at 0000H, external 0 vectors to 0003H and timer 0 to 000BH.
// - External 1 vectors to 0013H and timer 1 to 001BH.
// - Receive done, transmit done and SPI done share one source that vectors to 0023H.
// - With the global gate clear nothing is acknowledged, with it set each source needs its enable.
// - Enable bits sit at 5 timer 2, 3 timer 1, 2 external 1, 1 timer 0, 0 external 0, one enables.
// - Bit 4 of the enable register gates both the UART and the SPI request.
// - The enable register resets to zero and bit 6 is reserved.
// - The low level register holds one low priority bit per source at the enable bit positions.
// - The high level register holds one high priority bit per source at the same positions.
// - Idle stops the core while the interrupt logic keeps running.
// - During idle all register contents stay unchanged.
// - Idle ends on any enabled interrupt request or on a hardware reset.
// - A reset wake lets the core run up to two machine cycles with RAM writes blocked.
module icw_top #(
  parameter logic [15:0] TIMER2_VECTOR = 16'h002B,
  parameter int unsigned MCYC_CLKS = `ICW_OSC_PER_MCYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ext0_request_flag,
  input wire logic timer0_overflow_flag,
  input wire logic ext1_request_flag,
  input wire logic timer1_overflow_flag,
  input wire logic timer2_irq_flag,
  input wire logic receive_done_flag,
  input wire logic transmit_done_flag,
  input wire logic spi_xfer_done_flag,
  output logic irq_valid,
  output logic [15:0] irq_vector,
  input wire logic irq_ack,
  input wire logic irq_return,
  output logic [5:0] irq_taken,
  input wire logic reset_pin,
  output logic core_run,
  output logic ram_write_block,
  output logic sys_reset_req
);

  localparam int unsigned NSRC = 6;
  localparam logic [7:0] WAKE_LIMIT = 8'(`ICW_WAKE_MCYC * MCYC_CLKS);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  logic [7:0] enable_q;
  logic [7:0] lvl_hi_q;
  logic [7:0] lvl_lo_q;
  logic ap_wr_q;
  logic [7:0] ap_idx_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic addr_take;
  logic addr_ok;
  logic wr_en;
  logic wr_idle;
  logic [5:0] src_flag;
  logic [5:0] pend_vec;
  icw_pkg::icw_level_t lvl_arr [NSRC];
  logic best_found;
  icw_pkg::icw_src_t best_idx;
  icw_pkg::icw_level_t best_lvl;
  logic [3:0] in_service_q;
  logic [3:0] isr_d;
  logic isr_any;
  icw_pkg::icw_level_t isr_lvl;
  logic accept;
  logic irq_valid_q;
  logic [15:0] irq_vector_q;
  icw_pkg::icw_src_t irq_src_q;
  icw_pkg::icw_level_t irq_lvl_q;
  logic [5:0] irq_taken_q;
  icw_pkg::icw_state_e state_q;
  logic [1:0] wake_mcyc_q;
  logic mcyc_tick;
  logic [5:0] pend_d_q;
  logic isr_any_d_q;
  icw_pkg::icw_level_t isr_lvl_d_q;
  logic [7:0] wake_clks_q;

  // ----------------------------------------------------------------------
  // AHB-Lite slave.
  // ----------------------------------------------------------------------

  // Zero wait states keep the core's register accesses at bus speed.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign addr_take = hsel && htrans[1] && hready;
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);

  // Address phase capture for the following data phase.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ap_wr_q <= 1'b0;
      ap_idx_q <= 8'h00;
    end else begin
      ap_wr_q <= addr_take && hwrite && addr_ok;
      ap_idx_q <= haddr[9:2];
    end
  end

  // The core is asleep in idle, so any write seen then is dropped.
  assign wr_en = ap_wr_q && (state_q != icw_pkg::ST_IDLE);
  assign wr_idle = wr_en && (ap_idx_q == `ICW_IDX_CTRL) && hwdata[`ICW_CTRL_IDLE_BIT];

  // Read mux; unmapped words and reserved bits read as zero.
  always_comb begin
    case (haddr[9:2])
      `ICW_IDX_ENABLE: rd_mux = {24'h0, enable_q};
      `ICW_IDX_LVL_HI: rd_mux = {24'h0, lvl_hi_q};
      `ICW_IDX_LVL_LO: rd_mux = {24'h0, lvl_lo_q};
      `ICW_IDX_STATUS: rd_mux = {irq_vector_q, 5'h00, irq_src_q, 2'h0,
                                 state_q == icw_pkg::ST_IDLE, irq_valid_q, in_service_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is sampled at the address phase and stands in the data phase.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_take && !hwrite && addr_ok) begin
      hrdata_q <= rd_mux;
    end else begin
      hrdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Enable and level registers.
  // ----------------------------------------------------------------------

  // Enable register; the reserved bit never stores a one.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      enable_q <= `ICW_ENABLE_RST;
    end else if (wr_en && ap_idx_q == `ICW_IDX_ENABLE) begin
      enable_q <= hwdata[7:0] & `ICW_ENABLE_WMASK;
    end
  end

  // Level registers share the enable bit positions.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lvl_hi_q <= `ICW_LVL_RST;
      lvl_lo_q <= `ICW_LVL_RST;
    end else if (wr_en) begin
      if (ap_idx_q == `ICW_IDX_LVL_HI) begin
        lvl_hi_q <= hwdata[7:0] & `ICW_LVL_WMASK;
      end
      if (ap_idx_q == `ICW_IDX_LVL_LO) begin
        lvl_lo_q <= hwdata[7:0] & `ICW_LVL_WMASK;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Source gating and priority resolution.
  // ----------------------------------------------------------------------

  // The three serial events fold into the one serial source.
  assign src_flag = {timer2_irq_flag,
                     receive_done_flag | transmit_done_flag | spi_xfer_done_flag,
                     timer1_overflow_flag, ext1_request_flag,
                     timer0_overflow_flag, ext0_request_flag};

  for (genvar g = 0; g < NSRC; g++) begin : g_slot
    icw_slot_if sif ();
    assign sif.flag = src_flag[g];
    assign sif.en = enable_q[g];
    assign sif.gate = enable_q[`ICW_GATE_BIT];
    assign sif.lo = lvl_lo_q[g];
    assign sif.hi = lvl_hi_q[g];
    assign pend_vec[g] = sif.pend;
    assign lvl_arr[g] = sif.level;
    icw_slot u_slot (
      .s(sif)
    );
  end

  // Strictly greater keeps the earliest source on a tie, external 0 first.
  always_comb begin
    best_found = 1'b0;
    best_idx = 3'h0;
    best_lvl = 2'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (pend_vec[i] && (!best_found || lvl_arr[i] > best_lvl)) begin
        best_found = 1'b1;
        best_idx = 3'(i);
        best_lvl = lvl_arr[i];
      end
    end
  end

  // Highest level now in service.
  always_comb begin
    isr_any = |in_service_q;
    isr_lvl = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (in_service_q[i]) begin
        isr_lvl = 2'(i);
      end
    end
  end

  // Only a higher level may preempt; the ack cycle blocks a double offer.
  // No offer starts in the cycle that sends the core idle, so idle never shows one.
  assign accept = best_found && (state_q == icw_pkg::ST_RUN) && !wr_idle &&
                  (!isr_any || best_lvl > isr_lvl) && !(irq_valid_q && irq_ack);

  function automatic logic [15:0] vec_of(input icw_pkg::icw_src_t idx);
    case (idx)
      3'h0: vec_of = `ICW_VEC_EXT0;
      3'h1: vec_of = `ICW_VEC_TIMER0;
      3'h2: vec_of = `ICW_VEC_EXT1;
      3'h3: vec_of = `ICW_VEC_TIMER1;
      3'h4: vec_of = `ICW_VEC_SERIAL;
      default: vec_of = TIMER2_VECTOR;
    endcase
  endfunction : vec_of

  // ----------------------------------------------------------------------
  // Vector offer and in-service tracking.
  // ----------------------------------------------------------------------

  // After reset the vector output shows the start address.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_valid_q <= 1'b0;
      irq_vector_q <= `ICW_VEC_RESET;
      irq_src_q <= 3'h0;
      irq_lvl_q <= 2'h0;
    end else begin
      irq_valid_q <= accept;
      if (accept) begin
        irq_vector_q <= vec_of(best_idx);
        irq_src_q <= best_idx;
        irq_lvl_q <= best_lvl;
      end
    end
  end

  // A return and a new acceptance in one cycle: the new level wins.
  always_comb begin
    isr_d = in_service_q;
    if (irq_return && isr_any) begin
      isr_d[isr_lvl] = 1'b0;
    end
    if (irq_valid_q && irq_ack) begin
      isr_d[irq_lvl_q] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      in_service_q <= 4'h0;
      irq_taken_q <= 6'h00;
    end else begin
      in_service_q <= isr_d;
      irq_taken_q <= (irq_valid_q && irq_ack) ? (6'h01 << irq_src_q) : 6'h00;
    end
  end

  assign irq_valid = irq_valid_q;
  assign irq_vector = irq_vector_q;
  assign irq_taken = irq_taken_q;

  // ----------------------------------------------------------------------
  // Idle and wake sequencing.
  // ----------------------------------------------------------------------

  icw_mcyc_div #(
    .DIV(MCYC_CLKS)
  ) u_div (
    .clk(ref_clk),
    .srst(srst),
    .restart(state_q != icw_pkg::ST_WAKE_RST),
    .tick(mcyc_tick)
  );

  // Reset takes precedence over an interrupt wake in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= icw_pkg::ST_RUN;
    end else begin
      case (state_q)
        icw_pkg::ST_RUN: begin
          if (reset_pin) begin
            state_q <= icw_pkg::ST_RESET_OUT;
          end else if (wr_idle) begin
            state_q <= icw_pkg::ST_IDLE;
          end
        end
        icw_pkg::ST_IDLE: begin
          if (reset_pin) begin
            state_q <= icw_pkg::ST_WAKE_RST;
          end else if (|pend_vec) begin
            state_q <= icw_pkg::ST_RUN;
          end
        end
        icw_pkg::ST_WAKE_RST: begin
          if (mcyc_tick && wake_mcyc_q == 2'(`ICW_WAKE_MCYC - 1)) begin
            state_q <= icw_pkg::ST_RESET_OUT;
          end
        end
        icw_pkg::ST_RESET_OUT: begin
          if (!reset_pin) begin
            state_q <= icw_pkg::ST_RUN;
          end
        end
        default: state_q <= icw_pkg::ST_RUN;
      endcase
    end
  end

  // Machine cycles spent in the reset wake window.
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != icw_pkg::ST_WAKE_RST) begin
      wake_mcyc_q <= 2'h0;
    end else if (mcyc_tick) begin
      wake_mcyc_q <= wake_mcyc_q + 2'h1;
    end
  end

  // Ports stay writable in the wake window; only RAM writes are held off.
  assign core_run = (state_q == icw_pkg::ST_RUN) || (state_q == icw_pkg::ST_WAKE_RST);
  assign ram_write_block = (state_q == icw_pkg::ST_WAKE_RST) ||
                           (state_q == icw_pkg::ST_RESET_OUT);
  assign sys_reset_req = (state_q == icw_pkg::ST_RESET_OUT);

  // ----------------------------------------------------------------------
  // Assertions and their helper state.
  // ----------------------------------------------------------------------

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_d_q <= 6'h00;
      isr_any_d_q <= 1'b0;
      isr_lvl_d_q <= 2'h0;
      wake_clks_q <= 8'h00;
    end else begin
      pend_d_q <= pend_vec;
      isr_any_d_q <= isr_any;
      isr_lvl_d_q <= isr_lvl;
      wake_clks_q <= (state_q == icw_pkg::ST_WAKE_RST) ? wake_clks_q + 8'h01 : 8'h00;
    end
  end

  property p_gate_off;
    @(posedge ref_clk) disable iff (srst) !enable_q[`ICW_GATE_BIT] |=> !irq_valid_q;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("interrupt offered with global gate clear");

  property p_src_enabled;
    @(posedge ref_clk) disable iff (srst) irq_valid_q |-> pend_d_q[irq_src_q];
  endproperty
  a_src_enabled: assert property (p_src_enabled)
    else $error("offered source was not enabled and pending");

  property p_vec_ext0;
    @(posedge ref_clk) disable iff (srst)
      irq_valid_q && irq_src_q == 3'h0 |-> irq_vector_q == 16'h0003;
  endproperty
  a_vec_ext0: assert property (p_vec_ext0)
    else $error("external 0 vector wrong");

  property p_vec_ext1;
    @(posedge ref_clk) disable iff (srst)
      irq_valid_q && irq_src_q == 3'h2 |-> irq_vector_q == 16'h0013;
  endproperty
  a_vec_ext1: assert property (p_vec_ext1)
    else $error("external 1 vector wrong");

  property p_vec_serial;
    @(posedge ref_clk) disable iff (srst)
      irq_valid_q && irq_src_q == 3'h4 |-> irq_vector_q == 16'h0023;
  endproperty
  a_vec_serial: assert property (p_vec_serial)
    else $error("serial vector wrong");

  property p_serial_share;
    @(posedge ref_clk) disable iff (srst)
      spi_xfer_done_flag && enable_q[7] && enable_q[4] |-> pend_vec[4];
  endproperty
  a_serial_share: assert property (p_serial_share)
    else $error("SPI event not raised on the serial source");

  property p_reset_vals;
    @(posedge ref_clk) disable iff (srst)
      $fell(srst) |-> enable_q == 8'h00 && irq_vector_q == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("enable or start vector not at reset value");

  property p_preempt;
    @(posedge ref_clk) disable iff (srst)
      irq_valid_q && isr_any_d_q |-> irq_lvl_q > isr_lvl_d_q;
  endproperty
  a_preempt: assert property (p_preempt)
    else $error("offer does not outrank the level in service");

  property p_idle_stops;
    @(posedge ref_clk) disable iff (srst)
      state_q == icw_pkg::ST_IDLE |-> !core_run && !irq_valid_q ##1 !irq_taken_q[0];
  endproperty
  a_idle_stops: assert property (p_idle_stops)
    else $error("core running in idle");

  property p_idle_frozen;
    @(posedge ref_clk) disable iff (srst)
      state_q == icw_pkg::ST_IDLE && $past(state_q) == icw_pkg::ST_IDLE |->
        $stable(enable_q) && $stable(lvl_hi_q) && $stable(lvl_lo_q);
  endproperty
  a_idle_frozen: assert property (p_idle_frozen)
    else $error("register changed during idle");

  property p_idle_wake;
    @(posedge ref_clk) disable iff (srst)
      state_q == icw_pkg::ST_IDLE && (|pend_vec) && !reset_pin |=> core_run;
  endproperty
  a_idle_wake: assert property (p_idle_wake)
    else $error("enabled request did not end idle");

  property p_wake_window;
    @(posedge ref_clk) disable iff (srst)
      state_q == icw_pkg::ST_WAKE_RST |-> ram_write_block && wake_clks_q < WAKE_LIMIT;
  endproperty
  a_wake_window: assert property (p_wake_window)
    else $error("reset wake window too long or RAM writes open");

endmodule : icw_top

`default_nettype wire

// >>> shared/icw_regs.svh
`ifndef ICW_REGS_SVH
`define ICW_REGS_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------------
`define ICW_IDX_ENABLE 8'hA8
`define ICW_IDX_LVL_HI 8'hB7
`define ICW_IDX_LVL_LO 8'hB8
`define ICW_IDX_CTRL 8'hC0
`define ICW_IDX_STATUS 8'hC1

// ----------------------------------------------------------------------
// Field positions, masks and reset values.
// ----------------------------------------------------------------------
`define ICW_GATE_BIT 7
`define ICW_SER_BIT 4
`define ICW_CTRL_IDLE_BIT 0
`define ICW_ENABLE_WMASK 8'hBF
`define ICW_LVL_WMASK 8'h3F
`define ICW_ENABLE_RST 8'h00
`define ICW_LVL_RST 8'h00

// ----------------------------------------------------------------------
// Vector addresses.
// ----------------------------------------------------------------------
`define ICW_VEC_RESET 16'h0000
`define ICW_VEC_EXT0 16'h0003
`define ICW_VEC_TIMER0 16'h000B
`define ICW_VEC_EXT1 16'h0013
`define ICW_VEC_TIMER1 16'h001B
`define ICW_VEC_SERIAL 16'h0023

// ----------------------------------------------------------------------
// Timing counts.
// ----------------------------------------------------------------------
`define ICW_OSC_PER_MCYC 12
`define ICW_WAKE_MCYC 2

`endif

// >>> shared/icw_pkg.sv
package icw_pkg;

  // Idle and wake sequencing states.
  typedef enum logic [1:0] {
    ST_RUN,
    ST_IDLE,
    ST_WAKE_RST,
    ST_RESET_OUT
  } icw_state_e;

  // Two-bit priority level formed from the high and low level bits.
  typedef logic [1:0] icw_level_t;

  // Source index in polling order, external 0 first.
  typedef logic [2:0] icw_src_t;

endpackage : icw_pkg

// >>> shared/icw_slot_if.sv
`timescale 1ns/10ps
`default_nettype none

// Signals of one request source between the controller and its slot.
interface icw_slot_if;
  logic flag;
  logic en;
  logic gate;
  logic lo;
  logic hi;
  logic pend;
  icw_pkg::icw_level_t level;

  modport slot (input flag, input en, input gate, input lo, input hi, output pend, output level);
  modport ctl (output flag, output en, output gate, output lo, output hi, input pend, input level);
endinterface : icw_slot_if

`default_nettype wire

// >>> core/icw_slot.sv
`timescale 1ns/10ps
`default_nettype none

module icw_slot (
  icw_slot_if.slot s
);

  // A source requests only with the global gate, its own enable and its flag.
  assign s.pend = s.gate & s.en & s.flag;
  // The high bit ranks above the low bit, giving four levels.
  assign s.level = {s.hi, s.lo};

endmodule : icw_slot

`default_nettype wire

// >>> core/icw_mcyc_div.sv
`timescale 1ns/10ps
`default_nettype none
`include "icw_regs.svh"

module icw_mcyc_div #(
  parameter int unsigned DIV = `ICW_OSC_PER_MCYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic restart,
  output logic tick
);

  localparam int unsigned CW = $clog2(DIV);

  // The counter width and the wake window helper only cover this range.
  if (DIV < 2 || DIV > 64) begin : g_bad_div
    $error("icw_mcyc_div: DIV must lie between 2 and 64");
  end

  logic [CW-1:0] cnt_q;

  // Restart holds the count at zero so the first tick is a full cycle away.
  always_ff @(posedge clk) begin
    if (srst || restart) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick = !restart && (cnt_q == CW'(DIV - 1)); // End of one machine cycle.

endmodule : icw_mcyc_div

`default_nettype wire

// >>> verification/icw_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// Core side of the vector handshake: takes every offer while core_run is high, returns a few cycles later.
module icw_core_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic irq_valid,
  input wire logic core_run,
  output logic irq_ack,
  output logic irq_return
);
  logic [2:0] ret_cnt_q;

  // Ack is gated by core_run, so a stopped core never takes a vector.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      ret_cnt_q <= 3'h0;
    end else begin
      irq_ack <= irq_valid && core_run && !irq_ack;
      irq_return <= (ret_cnt_q == 3'h1);
      if (irq_ack) begin
        ret_cnt_q <= 3'h4;
      end else if (ret_cnt_q != 3'h0) begin
        ret_cnt_q <= ret_cnt_q - 3'h1;
      end
    end
  end
endmodule : icw_core_model

`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "icw_regs.svh"

module tb;
  // --------------------------------------------------------------------
  // Setup
  // --------------------------------------------------------------------
  localparam int unsigned MCYC = 3;
  localparam logic [15:0] T2V = 16'h002B;
  localparam logic [31:0] A_EN = {22'h000000, `ICW_IDX_ENABLE, 2'b00};
  localparam logic [31:0] A_HI = {22'h000000, `ICW_IDX_LVL_HI, 2'b00};
  localparam logic [31:0] A_LO = {22'h000000, `ICW_IDX_LVL_LO, 2'b00};
  localparam logic [31:0] A_CT = {22'h000000, `ICW_IDX_CTRL, 2'b00};
  localparam int SRC[8] = '{0, 1, 2, 3, 5, 4, 4, 4};
  localparam logic [15:0] VEC[8] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, T2V,
    16'h0023, 16'h0023, 16'h0023};
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [7:0] flg = 8'h00;
  logic reset_pin = 1'b0;
  logic hreadyout, hresp, irq_valid, irq_ack, irq_return, core_run, ram_write_block;
  logic sys_reset_req;
  logic [31:0] hrdata;
  logic [15:0] irq_vector;
  logic [5:0] irq_taken;
  int failures = 0;
  int samples_checked = 0;

  // Free-running clock at 125 MHz.
  always #4 ref_clk = ~ref_clk;

  icw_top #(.TIMER2_VECTOR(T2V), .MCYC_CLKS(MCYC)) icw_top_inst (
    .ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ext0_request_flag(flg[0]), .timer0_overflow_flag(flg[1]), .ext1_request_flag(flg[2]),
    .timer1_overflow_flag(flg[3]), .timer2_irq_flag(flg[4]), .receive_done_flag(flg[5]),
    .transmit_done_flag(flg[6]), .spi_xfer_done_flag(flg[7]), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .irq_ack(irq_ack), .irq_return(irq_return),
    .irq_taken(irq_taken), .reset_pin(reset_pin), .core_run(core_run),
    .ram_write_block(ram_write_block), .sys_reset_req(sys_reset_req));

  icw_core_model icw_core_model_inst (
    .ref_clk(ref_clk), .srst(srst), .irq_valid(irq_valid), .core_run(core_run),
    .irq_ack(irq_ack), .irq_return(irq_return));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One AHB-Lite single transfer; each phase is held until hready is seen high.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 100) begin
      chk("bus timeout", 32'h0, 32'h1);
      summarize();
    end
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(what, exp, r);
  endtask : rd

  function automatic logic pick(input int s);
    case (s)
      0: return irq_valid;
      1: return core_run;
      2: return sys_reset_req;
      3: return |irq_taken;
      default: return ram_write_block;
    endcase
  endfunction : pick

  // Bounded wait for a design output to reach a level.
  task automatic await(input int s, input logic v);
    int n;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pick(s) !== v && n < 60);
    if (n >= 60) begin
      chk("wait", {31'h0, v}, {31'h0, pick(s)});
      summarize();
    end
  endtask : await

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_regs();
    chk("reset vector", 32'h0, {16'h0, irq_vector});
    rd("enable rst", A_EN, 32'h0);
    wr(A_EN, 32'hFFFFFFFF);
    rd("enable", A_EN, 32'h000000BF);
    wr(A_HI, 32'h000000FF);
    rd("level hi", A_HI, 32'h0000003F);
    wr(A_LO, 32'h000000FF);
    rd("level lo", A_LO, 32'h0000003F);
    rd("unmapped", 32'h000003FC, 32'h0);
    wr(A_HI, 32'h0);
    wr(A_LO, 32'h0);
    wr(A_EN, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // Each source alone, with only the global gate and its own enable bit set.
  task automatic t_vectors();
    for (int k = 0; k < 8; k++) begin
      wr(A_EN, 32'h80 | (32'h1 << SRC[k]));
      flg[k] <= 1'b1;
      await(0, 1'b1);
      chk("vector", {16'h0, VEC[k]}, {16'h0, irq_vector});
      await(3, 1'b1);
      chk("taken", 32'h1 << SRC[k], {26'h0, irq_taken});
      flg <= 8'h00;
      repeat (8) @(posedge ref_clk);
    end
    $display("test vectors done");
  endtask : t_vectors

  task automatic t_gate();
    wr(A_EN, 32'h3F);
    flg <= 8'hFF;
    repeat (10) @(posedge ref_clk);
    chk("gate closed", 32'h0, {31'h0, irq_valid});
    flg <= 8'h00;
    wr(A_EN, 32'hAF);
    flg <= 8'hE0;
    repeat (10) @(posedge ref_clk);
    chk("serial off", 32'h0, {31'h0, irq_valid});
    flg <= 8'h00;
    wr(A_EN, 32'h0);
    $display("test gate done");
  endtask : t_gate

  // Timer 1 high, timer 0 low, external 0 at level zero: served high to low.
  task automatic t_prio();
    int bit_of[3] = '{3, 1, 0};
    logic [15:0] exp[3] = '{16'h001B, 16'h000B, 16'h0003};
    wr(A_HI, 32'h08);
    wr(A_LO, 32'h02);
    wr(A_EN, 32'h8F);
    flg <= 8'h0B;
    for (int j = 0; j < 3; j++) begin
      await(0, 1'b1);
      chk("prio vector", {16'h0, exp[j]}, {16'h0, irq_vector});
      await(3, 1'b1);
      flg[bit_of[j]] <= 1'b0;
    end
    // External 0 in service at level zero, then timer 1 at level two must preempt it.
    flg <= 8'h01;
    await(3, 1'b1);
    flg <= 8'h09;
    await(0, 1'b1);
    chk("preempt vector", 32'h001B, {16'h0, irq_vector});
    await(3, 1'b1);
    flg <= 8'h00;
    repeat (8) @(posedge ref_clk);
    wr(A_HI, 32'h0);
    wr(A_LO, 32'h0);
    $display("test priority done");
  endtask : t_prio

  // Nothing is written between idle entry and wake-up.
  task automatic t_idle();
    wr(A_EN, 32'h81);
    wr(A_CT, 32'h1);
    await(1, 1'b0);
    rd("enable in idle", A_EN, 32'h81);
    flg[0] <= 1'b1;
    await(1, 1'b1);
    await(0, 1'b1);
    chk("wake vector", 32'h0003, {16'h0, irq_vector});
    await(3, 1'b1);
    flg <= 8'h00;
    repeat (8) @(posedge ref_clk);
    $display("test idle done");
  endtask : t_idle

  task automatic t_rstwake();
    int n;
    wr(A_CT, 32'h1);
    await(1, 1'b0);
    reset_pin <= 1'b1;
    await(4, 1'b1);
    chk("core runs", 32'h1, {31'h0, core_run});
    n = 0;
    while (ram_write_block === 1'b1 && sys_reset_req !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      n++;
    end
    chk("wake window", 2 * MCYC, n);
    reset_pin <= 1'b0;
    await(2, 1'b0);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd("enable after reset", A_EN, 32'h0);
    $display("test reset wake done");
  endtask : t_rstwake

  // Main sequence.
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    t_vectors();
    t_gate();
    t_prio();
    t_idle();
    t_rstwake();
    summarize();
  end
endmodule : tb

`default_nettype wire
